// ### metering_bridge_map.svh
`ifndef METERING_BRIDGE_MAP_SVH
`define METERING_BRIDGE_MAP_SVH

// ----------------------------------------------------------------
// buffer register byte addresses
// ----------------------------------------------------------------
`define DATA_BYTE_0_OFFSET       16'h2880
`define DATA_BYTE_1_OFFSET       16'h2881
`define DATA_BYTE_2_OFFSET       16'h2882
`define DATA_BYTE_3_OFFSET       16'h2883
`define UNLOCK_INVALIDATE_OFFSET 16'h2884
`define TRANSFER_ACK_FLAG_OFFSET 16'h2885

// ----------------------------------------------------------------
// metering register window in the mcu address space
// ----------------------------------------------------------------
`define METER_WIN_BASE           16'h1000
`define METER_WIN_MASK           16'hF000

// ----------------------------------------------------------------
// values and reset defaults
// ----------------------------------------------------------------
`define UNLOCK_PATTERN           8'hCC
`define UNLOCK_CLEAR             8'h00
`define BUF_RESET                8'h00
`define ACK_BUSY                 8'h01
`define ACK_IDLE                 8'h00

// ----------------------------------------------------------------
// metering clock timing
// ----------------------------------------------------------------
`define CLK_FREQ_HZ              250000000
`define METER_CLK_BASE_HZ        819200
`define METER_CLK_DIV_X1         (`CLK_FREQ_HZ / `METER_CLK_BASE_HZ)
`define METER_CLK_DIV_X2         (`CLK_FREQ_HZ / (`METER_CLK_BASE_HZ * 2))
`define METER_CLK_DIV_X4         (`CLK_FREQ_HZ / (`METER_CLK_BASE_HZ * 4))
`define XFER_TIMEOUT_TICKS       5'd24

`endif

// ### metering_bridge_pkg.sv
package metering_bridge_pkg;

  // ----------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------
  typedef logic [7:0]  byte_t;       // one buffer byte
  typedef logic [15:0] mcu_addr_t;   // mcu byte address
  typedef logic [11:0] meter_addr_t; // metering register index

  // device side access sequencer
  typedef enum logic [1:0] {
    ST_LOCKED   = 2'b00,  // waiting for unlock pattern
    ST_GOT_CC   = 2'b01,  // pattern seen, waiting for zero
    ST_UNLOCKED = 2'b11,  // ready for target address
    ST_BUSY     = 2'b10   // transfer in progress
  } bridge_state_e;

  // mcu side access sequencer
  typedef enum logic [3:0] {
    HS_IDLE       = 4'b0000,
    HS_UNL_CC     = 4'b0001,
    HS_UNL_ZERO   = 4'b0011,
    HS_WR_DATA    = 4'b0010,
    HS_TARGET     = 4'b0110,
    HS_POLL_ISSUE = 4'b0111,
    HS_POLL_CHECK = 4'b0101,
    HS_RD_ISSUE   = 4'b0100,
    HS_RD_CAPTURE = 4'b1100,
    HS_FINISH     = 4'b1101
  } host_state_e;

endpackage

// ### metering_bus_if.sv
`timescale 1ns/1ps
interface metering_bus_if;
  logic [15:0] mcuAddr;    // byte address
  logic [7:0]  mcuWrData;  // write byte
  logic        mcuWrEn;    // write strobe, one cycle
  logic        mcuRdEn;    // read strobe, one cycle
  logic [7:0]  mcuRdData;  // read byte, valid cycle after strobe

  modport dev (
    input  mcuAddr,
    input  mcuWrData,
    input  mcuWrEn,
    input  mcuRdEn,
    output mcuRdData
  );

  modport mcu (
    output mcuAddr,
    output mcuWrData,
    output mcuWrEn,
    output mcuRdEn,
    input  mcuRdData
  );
endinterface

// ### metering_bridge_dev.sv
`timescale 1ns/1ps
`include "metering_bridge_map.svh"
module metering_bridge_dev
  import metering_bridge_pkg::*;
(
  input  wire logic        clk,                  // 250 MHz system clock
  input  wire logic        rst_n,                // synchronous reset, active low
  input  wire logic        powerOnBrownoutReset, // supply reset, active high
  input  wire logic        externalResetPin,     // pin reset, active high
  input  wire logic        watchdogTimerReset,   // watchdog overflow, active high
  input  wire logic [1:0]  meteringClockSelect,  // metering clock multiple
  metering_bus_if.dev      bus,                  // mcu byte bus
  output logic             meterReq,             // one cycle request to core
  output logic             meterWrite,           // request is a write
  output logic [11:0]      meterAddr,            // target register index
  output logic [31:0]      meterWrData,          // write word to core
  input  wire logic [31:0] meterRdData,          // read word from core
  input  wire logic        meterAck              // core done, one cycle
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // true for an address inside the metering register window
  function automatic logic isTarget(input mcu_addr_t a);
    isTarget = (a & `METER_WIN_MASK) == `METER_WIN_BASE;
  endfunction

  // true for one of the four data buffer bytes
  function automatic logic isDataByte(input mcu_addr_t a);
    isDataByte = (a >= `DATA_BYTE_0_OFFSET) && (a <= `DATA_BYTE_3_OFFSET);
  endfunction

  // metering clock period in system cycles for a select code
  function automatic logic [8:0] tickPeriod(input logic [1:0] sel);
    case (sel)
      2'b01:   tickPeriod = 9'(`METER_CLK_DIV_X2);
      2'b10:   tickPeriod = 9'(`METER_CLK_DIV_X4);
      default: tickPeriod = 9'(`METER_CLK_DIV_X1);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state and internal signals
  // ----------------------------------------------------------------
  bridge_state_e state;          // access sequencer
  byte_t         dataByte [4];   // data buffer bytes, lsb first
  logic          bufClear;       // any of the buffer resets
  logic          wrUnlock;       // write to unlock/invalidate byte
  logic          tgtAccess;      // mcu access to metering window
  logic          startXfer;      // accepted target address
  logic          xferDone;       // transfer ends this cycle
  logic          xferWrite;      // pending transfer is a write
  logic          reqPending;     // request not yet sent to core
  logic [8:0]    divCount;       // metering clock divider
  logic          mtTick;         // one cycle per metering clock period
  logic [4:0]    tickCount;      // metering periods since start
  logic [1:0]    byteIdx;        // decoded data byte index

  assign bufClear  = !rst_n || powerOnBrownoutReset ||
                     externalResetPin || watchdogTimerReset;
  assign wrUnlock  = bus.mcuWrEn && (bus.mcuAddr == `UNLOCK_INVALIDATE_OFFSET);
  assign tgtAccess = (bus.mcuWrEn || bus.mcuRdEn) && isTarget(bus.mcuAddr);
  assign startXfer = tgtAccess && (state == ST_UNLOCKED);
  // a core answer before the request pulse must not end the transfer
  assign xferDone  = (state == ST_BUSY) &&
                     ((meterAck && !reqPending) || (tickCount == `XFER_TIMEOUT_TICKS));
  assign byteIdx   = bus.mcuAddr[1:0];

  // ----------------------------------------------------------------
  // metering clock tick
  // ----------------------------------------------------------------

  // divider makes one tick per metering clock period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCount <= 9'h000;
      mtTick   <= 1'b0;
    end else if (divCount >= tickPeriod(meteringClockSelect) - 9'h001) begin
      divCount <= 9'h000;
      mtTick   <= 1'b1;
    end else begin
      divCount <= divCount + 9'h001;
      mtTick   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------

  // unlock pattern, address acceptance and completion
  always_ff @(posedge clk) begin
    if (bufClear) begin
      state <= ST_LOCKED;
    end else begin
      case (state)
        ST_LOCKED: begin
          // pattern opens the sequence
          if (wrUnlock && bus.mcuWrData == `UNLOCK_PATTERN) begin
            state <= ST_GOT_CC;
          end
        end
        ST_GOT_CC: begin
          // zero completes it, anything else invalidates
          if (wrUnlock) begin
            state <= (bus.mcuWrData == `UNLOCK_CLEAR) ? ST_UNLOCKED : ST_LOCKED;
          end
        end
        ST_UNLOCKED: begin
          // a later write to the unlock byte invalidates
          if (wrUnlock) begin
            state <= (bus.mcuWrData == `UNLOCK_PATTERN) ? ST_GOT_CC : ST_LOCKED;
          end else if (startXfer) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // new addresses ignored until done; relock afterwards
          if (xferDone) begin
            state <= ST_LOCKED;
          end
        end
        default: begin
          state <= ST_LOCKED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transfer timing
  // ----------------------------------------------------------------

  // counts metering periods from address acceptance
  always_ff @(posedge clk) begin
    if (bufClear) begin
      tickCount <= 5'd0;
    end else if (startXfer) begin
      tickCount <= 5'd0;
    end else if (state == ST_BUSY && mtTick) begin
      tickCount <= tickCount + 5'd1;
    end
  end

  // latches target, direction and write word at acceptance
  always_ff @(posedge clk) begin
    if (bufClear) begin
      xferWrite   <= 1'b0;
      meterAddr   <= 12'h000;
      meterWrData <= 32'h0000_0000;
    end else if (startXfer) begin
      xferWrite   <= bus.mcuWrEn;
      meterAddr   <= bus.mcuAddr[11:0];
      meterWrData <= {dataByte[3], dataByte[2], dataByte[1], dataByte[0]};
    end
  end

  // one request pulse on the first metering tick of a transfer
  always_ff @(posedge clk) begin
    if (bufClear) begin
      reqPending <= 1'b0;
      meterReq   <= 1'b0;
      meterWrite <= 1'b0;
    end else if (startXfer) begin
      reqPending <= 1'b1;
      meterReq   <= 1'b0;
    end else if (state == ST_BUSY && reqPending && mtTick) begin
      reqPending <= 1'b0;
      meterReq   <= 1'b1;
      meterWrite <= xferWrite;
    end else begin
      meterReq   <= 1'b0;
      if (xferDone) begin
        reqPending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // data buffer bytes
  // ----------------------------------------------------------------

  // mcu writes, or load from core on a read answer
  always_ff @(posedge clk) begin
    if (bufClear) begin
      for (int i = 0; i < 4; i++) begin
        dataByte[i] <= `BUF_RESET;
      end
    end else if (state == ST_BUSY && meterAck && !xferWrite && !reqPending) begin
      for (int i = 0; i < 4; i++) begin
        dataByte[i] <= meterRdData[8*i +: 8];
      end
    end else if (bus.mcuWrEn && isDataByte(bus.mcuAddr) && state != ST_BUSY) begin
      dataByte[byteIdx] <= bus.mcuWrData;
    end
  end

  // ----------------------------------------------------------------
  // mcu read port
  // ----------------------------------------------------------------

  // registered read answer, unmapped and write only read zero
  always_ff @(posedge clk) begin
    if (bufClear) begin
      bus.mcuRdData <= `BUF_RESET;
    end else if (bus.mcuRdEn) begin
      if (isDataByte(bus.mcuAddr)) begin
        bus.mcuRdData <= dataByte[byteIdx];
      end else if (bus.mcuAddr == `TRANSFER_ACK_FLAG_OFFSET) begin
        bus.mcuRdData <= (state == ST_BUSY) ? `ACK_BUSY : `ACK_IDLE;
      end else begin
        bus.mcuRdData <= `BUF_RESET;
      end
    end
  end

endmodule

// ### metering_bridge_host.sv
`timescale 1ns/1ps
`include "metering_bridge_map.svh"
module metering_bridge_host
  import metering_bridge_pkg::*;
(
  input  wire logic        clk,        // 250 MHz system clock
  input  wire logic        rst_n,      // synchronous reset, active low
  input  wire logic        cmdValid,   // start an access, level
  input  wire logic        cmdWrite,   // access is a write
  input  wire logic [15:0] cmdAddr,    // target address in metering window
  input  wire logic [31:0] cmdWrData,  // word to write
  output logic             cmdReady,   // idle, command taken when valid
  output logic             rspValid,   // access finished, one cycle
  output logic [31:0]      rspData,    // word read
  metering_bus_if.mcu      bus         // mcu byte bus
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  host_state_e state;       // access sequencer
  logic        isWrite;     // latched direction
  logic [15:0] tgtAddr;     // latched target address
  logic [31:0] wrWord;      // latched write word
  logic [1:0]  idx;         // byte index

  // ----------------------------------------------------------------
  // sequencer and bus drive
  // ----------------------------------------------------------------

  // unlock, data, address, poll, collect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= HS_IDLE;
      isWrite       <= 1'b0;
      tgtAddr       <= 16'h0000;
      wrWord        <= 32'h0000_0000;
      idx           <= 2'd0;
      cmdReady      <= 1'b0;
      rspValid      <= 1'b0;
      rspData       <= 32'h0000_0000;
      bus.mcuAddr   <= 16'h0000;
      bus.mcuWrData <= 8'h00;
      bus.mcuWrEn   <= 1'b0;
      bus.mcuRdEn   <= 1'b0;
    end else begin
      // strobes last one cycle
      bus.mcuWrEn <= 1'b0;
      bus.mcuRdEn <= 1'b0;
      rspValid    <= 1'b0;
      case (state)
        HS_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady      <= 1'b0;
            isWrite       <= cmdWrite;
            tgtAddr       <= cmdAddr;
            wrWord        <= cmdWrData;
            bus.mcuAddr   <= `UNLOCK_INVALIDATE_OFFSET;
            bus.mcuWrData <= `UNLOCK_PATTERN;
            bus.mcuWrEn   <= 1'b1;
            state         <= HS_UNL_CC;
          end
        end
        HS_UNL_CC: begin
          bus.mcuAddr   <= `UNLOCK_INVALIDATE_OFFSET;
          bus.mcuWrData <= `UNLOCK_CLEAR;
          bus.mcuWrEn   <= 1'b1;
          state         <= HS_UNL_ZERO;
        end
        HS_UNL_ZERO: begin
          if (isWrite) begin
            // data goes in before the address
            bus.mcuAddr   <= `DATA_BYTE_0_OFFSET;
            bus.mcuWrData <= wrWord[7:0];
            bus.mcuWrEn   <= 1'b1;
            idx           <= 2'd1;
            state         <= HS_WR_DATA;
          end else begin
            bus.mcuAddr <= tgtAddr;
            bus.mcuRdEn <= 1'b1;
            state       <= HS_TARGET;
          end
        end
        HS_WR_DATA: begin
          bus.mcuWrEn <= 1'b1;
          if (idx != 2'd0) begin
            bus.mcuAddr   <= `DATA_BYTE_0_OFFSET + {14'h0000, idx};
            bus.mcuWrData <= wrWord[8*idx +: 8];
            idx           <= idx + 2'd1;
          end else begin
            bus.mcuAddr   <= tgtAddr;
            bus.mcuWrData <= 8'h00;
            state         <= HS_TARGET;
          end
        end
        HS_TARGET: begin
          bus.mcuAddr <= `TRANSFER_ACK_FLAG_OFFSET;
          bus.mcuRdEn <= 1'b1;
          state       <= HS_POLL_ISSUE;
        end
        HS_POLL_ISSUE: begin
          state <= HS_POLL_CHECK;
        end
        HS_POLL_CHECK: begin
          // no data is taken until the flag reads zero
          if (bus.mcuRdData != `ACK_IDLE) begin
            bus.mcuAddr <= `TRANSFER_ACK_FLAG_OFFSET;
            bus.mcuRdEn <= 1'b1;
            state       <= HS_POLL_ISSUE;
          end else if (isWrite) begin
            state <= HS_FINISH;
          end else begin
            bus.mcuAddr <= `DATA_BYTE_0_OFFSET;
            bus.mcuRdEn <= 1'b1;
            idx         <= 2'd0;
            state       <= HS_RD_ISSUE;
          end
        end
        HS_RD_ISSUE: begin
          state <= HS_RD_CAPTURE;
        end
        HS_RD_CAPTURE: begin
          rspData[8*idx +: 8] <= bus.mcuRdData;
          if (idx == 2'd3) begin
            state <= HS_FINISH;
          end else begin
            bus.mcuAddr <= `DATA_BYTE_0_OFFSET + {14'h0000, idx + 2'd1};
            bus.mcuRdEn <= 1'b1;
            idx         <= idx + 2'd1;
            state       <= HS_RD_ISSUE;
          end
        end
        HS_FINISH: begin
          rspValid <= 1'b1;
          cmdReady <= 1'b1;
          state    <= HS_IDLE;
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

endmodule

// ### metering_bridge_asserts.sv
`timescale 1ns/1ps
`include "metering_bridge_map.svh"
module metering_bridge_asserts (
  input wire logic        clk,       // system clock
  input wire logic        rst_n,     // sync reset, active low
  input wire logic [15:0] mcuAddr,   // byte address
  input wire logic [7:0]  mcuWrData, // write byte
  input wire logic        mcuWrEn,   // write strobe
  input wire logic        mcuRdEn,   // read strobe
  input wire logic [7:0]  mcuRdData  // read byte
);
  // ------------------------------------------------
  // address decode helpers
  // ------------------------------------------------
  logic inWin; // inside metering window
  logic isBuf; // one of the six buffer bytes
  logic isDat; // one of the four data bytes
  assign inWin = (mcuAddr & `METER_WIN_MASK) == `METER_WIN_BASE;
  assign isBuf = mcuAddr >= `DATA_BYTE_0_OFFSET && mcuAddr <= `TRANSFER_ACK_FLAG_OFFSET;
  assign isDat = mcuAddr >= `DATA_BYTE_0_OFFSET && mcuAddr <= `DATA_BYTE_3_OFFSET;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------
  // bus sequencing checks
  // ------------------------------------------------
  unlock_order_a: assert property (
    mcuWrEn && mcuAddr == `UNLOCK_INVALIDATE_OFFSET && mcuWrData == `UNLOCK_PATTERN |=>
    mcuWrEn && mcuAddr == `UNLOCK_INVALIDATE_OFFSET && mcuWrData == `UNLOCK_CLEAR)
    else $error("unlock pattern not followed by zero");
  after_unlock_a: assert property (
    mcuWrEn && mcuAddr == `UNLOCK_INVALIDATE_OFFSET && mcuWrData == `UNLOCK_CLEAR |=>
    (mcuWrEn && mcuAddr == `DATA_BYTE_0_OFFSET) || (mcuRdEn && inWin))
    else $error("unlock not followed by data load or target read");
  data_load_order_a: assert property (
    mcuWrEn && mcuAddr == `DATA_BYTE_0_OFFSET |=> mcuWrEn && mcuAddr == `DATA_BYTE_1_OFFSET
    ##1 mcuWrEn && mcuAddr == `DATA_BYTE_2_OFFSET ##1 mcuWrEn && mcuAddr == `DATA_BYTE_3_OFFSET
    ##1 mcuWrEn && inWin)
    else $error("data bytes not loaded in order before target");
  legal_target_a: assert property ((mcuWrEn || mcuRdEn) |-> isBuf || inWin)
    else $error("access outside buffers and window");
  strobe_excl_a: assert property (!(mcuWrEn && mcuRdEn))
    else $error("read and write strobes together");
  busy_poll_a: assert property (
    (mcuWrEn || mcuRdEn) && inWin |=> mcuRdEn && mcuAddr == `TRANSFER_ACK_FLAG_OFFSET
    ##1 mcuRdData == `ACK_BUSY)
    else $error("flag not busy right after target access");
  no_early_take_a: assert property (
    mcuRdEn && mcuAddr == `TRANSFER_ACK_FLAG_OFFSET ##1 mcuRdData != `ACK_IDLE |->
    !(mcuRdEn && isDat) [*3])
    else $error("data taken while transfer pending");
  byte_read_order_a: assert property (
    mcuRdEn && mcuAddr == `DATA_BYTE_0_OFFSET |->
    ##[1:3] (mcuRdEn && mcuAddr == `DATA_BYTE_1_OFFSET))
    else $error("data bytes not read in order");
endmodule

// ### test_metering_register_access_bridge.sv
`timescale 1ns/1ps
`include "metering_bridge_map.svh"
module test_metering_register_access_bridge
  import metering_bridge_pkg::*;
();
  // ------------------------------------------------
  // signals and bench state
  // ------------------------------------------------
  logic        clk, rst_n, supplyRst, extRst, dogRst; // clock and resets
  logic [1:0]  mtSel;                            // metering clock select
  logic        meterReq, meterWrite, meterAck;   // core link
  logic [11:0] meterAddr;                        // core index
  logic [31:0] meterWrData, meterRdData;         // core words
  logic        cmdValid, cmdWrite, cmdReady;     // host command
  logic [15:0] cmdAddr;                          // host target
  logic [31:0] cmdWrData, rspData;               // host words
  logic        rspValid;                         // host done
  int          num_errors = 0;                   // mismatches
  int          n_checks = 0;                     // comparisons
  int          cycles = 0;                       // hang guard
  integer      seed = 74538;                     // random seed
  logic        ackOn;                            // core answers
  logic [31:0] coreMem [0:4095];                 // core register model
  logic [31:0] lastBytes;                        // expected buffer word
  logic [44:0] reqQ [$];                         // expected core requests
  logic [32:0] rspQ [$];                         // expected host answers

  metering_bus_if bif ();
  metering_bridge_host u_metering_bridge_host (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .bus(bif));
  metering_bridge_dev u_metering_bridge_dev (.clk(clk), .rst_n(rst_n),
    .powerOnBrownoutReset(supplyRst), .externalResetPin(extRst), .watchdogTimerReset(dogRst),
    .meteringClockSelect(mtSel), .bus(bif), .meterReq(meterReq), .meterWrite(meterWrite),
    .meterAddr(meterAddr), .meterWrData(meterWrData), .meterRdData(meterRdData),
    .meterAck(meterAck));
  metering_bridge_asserts u_metering_bridge_asserts (.clk(clk), .rst_n(rst_n),
    .mcuAddr(bif.mcuAddr), .mcuWrData(bif.mcuWrData), .mcuWrEn(bif.mcuWrEn),
    .mcuRdEn(bif.mcuRdEn), .mcuRdData(bif.mcuRdData));

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic check(input string what, input logic [44:0] seen, input logic [44:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one host command, notes expectations, returns cycles to done
  task automatic do_cmd(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        output int lat);
    @(posedge clk);
    #1;
    cmdWrite = wr;
    cmdAddr = a;
    cmdWrData = d;
    cmdValid = 1'b1;
    reqQ.push_back({wr, a[11:0], wr ? d : 32'h0});
    if (!wr && ackOn) lastBytes = coreMem[a[11:0]];
    if (wr) lastBytes = d;
    rspQ.push_back({!wr, lastBytes});
    do @(negedge clk); while (cmdReady !== 1'b1);
    @(posedge clk);
    #1 cmdValid = 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (rspValid !== 1'b1);
  endtask

  // ------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial forever begin
    @(posedge clk);
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      report_and_stop;
    end
  end

  // ------------------------------------------------
  // core model: checks each request, answers late
  // ------------------------------------------------
  initial begin
    logic [44:0] e;
    logic [44:0] s;
    int          dly;
    meterAck = 1'b0;
    meterRdData = 32'h0;
    forever begin
      @(negedge clk);
      if (meterReq === 1'b1) begin
        e = reqQ.size() > 0 ? reqQ.pop_front() : '1;
        s = {meterWrite, meterAddr, meterWrite ? meterWrData : 32'h0};
        check("core request", s, e);
        if (ackOn) begin
          dly = 3 + ($random(seed) & 15);
          repeat (dly) @(posedge clk);
          #1;
          meterAck = 1'b1;
          meterRdData = coreMem[meterAddr];
          if (meterWrite) coreMem[meterAddr] = meterWrData;
          @(posedge clk);
          #1;
          meterAck = 1'b0;
          meterRdData = ~meterRdData;
        end
      end
    end
  end

  // answer monitor: oldest note against each read result
  initial forever begin
    logic [32:0] r;
    @(negedge clk);
    if (rspValid === 1'b1) begin
      r = rspQ.pop_front();
      if (r[32]) check("read word", rspData, r[31:0]);
    end
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    int          lat, i, p;
    logic [15:0] a;
    logic [31:0] d;
    rst_n = 1'b0;
    {supplyRst, extRst, dogRst} = 3'b000;
    mtSel = 2'b10;
    {cmdValid, cmdWrite} = 2'b00;
    cmdAddr = 16'h0;
    cmdWrData = 32'h0;
    ackOn = 1'b1;
    lastBytes = 32'h0;
    for (i = 0; i < 4096; i++) coreMem[i] = 32'hA5000000 ^ i;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    // write, read back, read elsewhere, edges of the window included
    for (i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'h1000 : (i == 1) ? 16'h1FFF : 16'h1000 | 16'($random(seed) & 16'h0FFF);
      d = $random(seed);
      do_cmd(1'b1, a, d, lat);
      do_cmd(1'b0, a, 32'h0, lat);
      do_cmd(1'b0, 16'h1000 | 16'($random(seed) & 16'h0FFF), 32'h0, lat);
    end
    $display("test random transfers done");
    // each reset source, then unanswered read timed by each select
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      mtSel = i[1:0];
      {supplyRst, extRst, dogRst} = (i < 3) ? (3'b100 >> i) : 3'b000;
      if (i == 3) rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      {supplyRst, extRst, dogRst} = 3'b000;
      rst_n = 1'b1;
      lastBytes = 32'h0;
      ackOn = 1'b0;
      do_cmd(1'b0, 16'h1000 | 16'($random(seed) & 16'h0FFF), 32'h0, lat);
      ackOn = 1'b1;
      p = (i == 1) ? `METER_CLK_DIV_X2 : (i == 2) ? `METER_CLK_DIV_X4 : `METER_CLK_DIV_X1;
      check("timeout span", lat >= 23 * p && lat <= 25 * p + 40, 1'b1);
      $display("test reset and select %0d done", i);
    end
    report_and_stop;
  end
endmodule
